// ==== hw/lamp_regs_pkg.sv ====
// constants, field layouts and carriers for the lamp and transceiver control registers
package lamp_regs_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, printed offsets as indices on the management port
	localparam logic [4:0]  LAMP_CTRL_IDX     = 5'h18;
	localparam logic [4:0]  XCVR_CTRL_IDX     = 5'h19;

	////////////////////////////////////////////////////////////////////////
	// lamp control fields
	localparam int          LC_RATE_LSB       = 9;
	localparam int          LC_POL_LSB        = 6;
	localparam int          LC_FORCE_LSB      = 3;
	localparam int          LC_VALUE_LSB      = 0;
	localparam logic [1:0]  RATE_RST          = 2'h2;
	localparam logic [2:0]  POL_RST           = 3'h7;
	localparam logic [2:0]  FORCE_RST         = 3'h0;
	localparam logic [2:0]  VALUE_RST         = 3'h0;

	// lamp index inside the three-bit lamp fields
	localparam int          LAMP_SPD          = 2;
	localparam int          LAMP_LNK          = 1;
	localparam int          LAMP_ACT          = 0;

	////////////////////////////////////////////////////////////////////////
	// transceiver control fields
	localparam int          XC_AUTO_XOVER     = 15;
	localparam int          XC_FORCE_XOVER    = 14;
	localparam int          XC_PAUSE_RX       = 13;
	localparam int          XC_PAUSE_TX       = 12;
	localparam int          XC_LINK_STAT      = 11;
	localparam int          XC_BYPASS         = 7;
	localparam int          XC_MODE_LSB       = 5;
	localparam int          XC_ADDR_LSB       = 0;
	localparam logic        AUTO_XOVER_RST    = 1'b1;
	localparam logic        FORCE_XOVER_RST   = 1'b0;
	localparam logic        BYPASS_RST        = 1'b0;
	localparam logic [1:0]  MODE_RST          = 2'h0;
	localparam logic [4:0]  ADDR_RST          = 5'h01;

	////////////////////////////////////////////////////////////////////////
	// timing: blink on/off times and stretch time in ms, clock in cycles per ms
	localparam int          CLK_MHZ           = 200;
	localparam int          CYC_PER_MS        = CLK_MHZ * 1000;
	localparam int          BLINK_MS_0        = 50;
	localparam int          BLINK_MS_1        = 100;
	localparam int          BLINK_MS_2        = 200;
	localparam int          BLINK_MS_3        = 500;
	localparam int          STRETCH_MS        = 50;
	localparam int          BLINK_CYC_0       = BLINK_MS_0 * CYC_PER_MS;
	localparam int          BLINK_CYC_1       = BLINK_MS_1 * CYC_PER_MS;
	localparam int          BLINK_CYC_2       = BLINK_MS_2 * CYC_PER_MS;
	localparam int          BLINK_CYC_3       = BLINK_MS_3 * CYC_PER_MS;
	localparam int          STRETCH_CYC       = STRETCH_MS * CYC_PER_MS;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       link_up;
		logic       speed_100;
		logic       full_duplex;
		logic       activity;
		logic       collision;
		logic       an_done;
		logic [1:0] local_pause;
		logic [1:0] partner_pause;
	} phy_status_s;

	typedef struct packed {
		logic       speed_pol;
		logic       link_pol;
		logic       act_pol;
		logic       auto_xover;
		logic       mode0;
		logic [4:0] port_addr;
	} strap_s;

endpackage

// ==== hw/led_and_phy_control_regs.sv ====
// lamp drive and general transceiver control registers with strap capture
//
// Overview of operation
// - blink-rate field picks 50/100/200/500 ms, reset 10
// - speed lamp polarity from strap, software overridable
// - link lamp polarity from strap, software overridable
// - activity lamp polarity from strap, software overridable
// - force-speed drives speed lamp with value bit
// - force-link drives link lamp with value bit
// - force-activity drives activity lamp with value bit
// - reserved bits ignore writes, read zero
// - auto crossover enable from strap, default one
// - forced crossover swaps transmit and receive pairs
// - pause-receive status resolved from pause advertisements
// - pause-transmit status resolved from same advertisements
// - pause bits only when result is full duplex
// - link bit: negotiated 100 full-duplex link active
// - stretch bypass makes lamps follow raw status
// - mode 1: link, speed, activity pulse
// - mode 2: link, collision on activity lamp
// - mode 3: link blinks on activity, duplex lamp
`timescale 1ns/1ps

module led_and_phy_control_regs #(
	parameter int CNT_W       = 27,
	parameter int BLINK_CYC_0 = lamp_regs_pkg::BLINK_CYC_0,
	parameter int BLINK_CYC_1 = lamp_regs_pkg::BLINK_CYC_1,
	parameter int BLINK_CYC_2 = lamp_regs_pkg::BLINK_CYC_2,
	parameter int BLINK_CYC_3 = lamp_regs_pkg::BLINK_CYC_3,
	parameter int STRETCH_CYC = lamp_regs_pkg::STRETCH_CYC
)
(
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic [4:0]                   addr_i,
	input  wire logic [15:0]                  wr_data_i,
	input  wire logic                         wr_en_i,
	input  wire logic                         rd_en_i,
	output logic      [15:0]                  rd_data_o,
	input  wire lamp_regs_pkg::phy_status_s   status_i,
	input  wire lamp_regs_pkg::strap_s        strap_i,
	output logic                              speed_lamp_out_o,
	output logic                              link_lamp_out_o,
	output logic                              activity_lamp_out_o,
	output logic                              auto_xover_en_o,
	output logic                              pair_swap_o,
	output logic                              pause_rx_en_o,
	output logic                              pause_tx_en_o
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	lamp_regs_pkg::strap_s strap_meta_ff;
	lamp_regs_pkg::strap_s strap_sync_ff;
	logic                  load_pending_ff;
	logic [1:0]            rate_ff;
	logic [2:0]            pol_ff;
	logic [2:0]            force_ff;
	logic [2:0]            value_ff;
	logic                  auto_xover_ff;
	logic                  force_xover_ff;
	logic                  bypass_ff;
	logic [1:0]            mode_ff;
	logic [4:0]            addr_ff;
	logic                  pause_rx_ff;
	logic                  pause_tx_ff;
	logic                  link_stat_ff;
	logic [15:0]           rd_data_ff;
	logic [15:0]           nxt_rd_data;
	logic                  wr_lamp;
	logic                  wr_xcvr;
	logic [CNT_W-1:0]      blink_cnt_ff;
	logic [CNT_W-1:0]      blink_sel;
	logic                  blink_phase_ff;
	logic [CNT_W-1:0]      str_cnt_ff [2];
	logic [1:0]            str_src;
	logic [1:0]            str_out;
	logic                  act_ev;
	logic                  col_ev;
	logic [2:0]            lamp_on;
	logic [2:0]            lamp_drv;
	logic [2:0]            lamp_out_ff;
	logic                  hcd_fd;
	logic                  nxt_pause_rx;
	logic                  nxt_pause_tx;

	assign wr_lamp = wr_en_i && (addr_i == lamp_regs_pkg::LAMP_CTRL_IDX);
	assign wr_xcvr = wr_en_i && (addr_i == lamp_regs_pkg::XCVR_CTRL_IDX);

	////////////////////////////////////////////////////////////////////////
	// strap synchroniser and one-shot load after reset release
	always_ff @(posedge core_clk_i)
	begin
		strap_meta_ff <= strap_i;
		strap_sync_ff <= strap_meta_ff;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			load_pending_ff <= 1'b1;
		else
			load_pending_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// lamp control register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			rate_ff  <= lamp_regs_pkg::RATE_RST;
			pol_ff   <= lamp_regs_pkg::POL_RST;
			force_ff <= lamp_regs_pkg::FORCE_RST;
			value_ff <= lamp_regs_pkg::VALUE_RST;
		end
		else if (wr_lamp)
		begin
			rate_ff  <= wr_data_i[lamp_regs_pkg::LC_RATE_LSB +: 2];
			pol_ff   <= wr_data_i[lamp_regs_pkg::LC_POL_LSB +: 3];
			force_ff <= wr_data_i[lamp_regs_pkg::LC_FORCE_LSB +: 3];
			value_ff <= wr_data_i[lamp_regs_pkg::LC_VALUE_LSB +: 3];
		end
		else if (load_pending_ff)
		begin
			pol_ff <= {strap_sync_ff.speed_pol, strap_sync_ff.link_pol, strap_sync_ff.act_pol};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transceiver control register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			auto_xover_ff  <= lamp_regs_pkg::AUTO_XOVER_RST;
			force_xover_ff <= lamp_regs_pkg::FORCE_XOVER_RST;
			bypass_ff      <= lamp_regs_pkg::BYPASS_RST;
			mode_ff        <= lamp_regs_pkg::MODE_RST;
		end
		else if (wr_xcvr)
		begin
			auto_xover_ff  <= wr_data_i[lamp_regs_pkg::XC_AUTO_XOVER];
			force_xover_ff <= wr_data_i[lamp_regs_pkg::XC_FORCE_XOVER];
			bypass_ff      <= wr_data_i[lamp_regs_pkg::XC_BYPASS];
			mode_ff        <= wr_data_i[lamp_regs_pkg::XC_MODE_LSB +: 2];
		end
		else if (load_pending_ff)
		begin
			auto_xover_ff <= strap_sync_ff.auto_xover;
			mode_ff[0]    <= strap_sync_ff.mode0;
		end
	end

	// port address is read-only, taken from the strap once
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			addr_ff <= lamp_regs_pkg::ADDR_RST;
		else if (load_pending_ff)
			addr_ff <= strap_sync_ff.port_addr;
	end

	assign auto_xover_en_o = auto_xover_ff;
	assign pair_swap_o     = force_xover_ff;

	////////////////////////////////////////////////////////////////////////
	// pause resolution and negotiated link status
	assign hcd_fd = status_i.an_done && status_i.full_duplex;

	always_comb
	begin
		nxt_pause_rx = 1'b0;
		nxt_pause_tx = 1'b0;
		if (hcd_fd)
		begin
			if (status_i.local_pause[0] && status_i.partner_pause[0])
			begin
				nxt_pause_rx = 1'b1;
				nxt_pause_tx = 1'b1;
			end
			else if (!status_i.local_pause[0] && status_i.local_pause[1] &&
			         status_i.partner_pause[0] && status_i.partner_pause[1])
			begin
				nxt_pause_tx = 1'b1;
			end
			else if (status_i.local_pause[0] && status_i.local_pause[1] &&
			         !status_i.partner_pause[0] && status_i.partner_pause[1])
			begin
				nxt_pause_rx = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			pause_rx_ff  <= 1'b0;
			pause_tx_ff  <= 1'b0;
			link_stat_ff <= 1'b0;
		end
		else
		begin
			pause_rx_ff  <= nxt_pause_rx;
			pause_tx_ff  <= nxt_pause_tx;
			link_stat_ff <= hcd_fd && status_i.link_up && status_i.speed_100;
		end
	end

	assign pause_rx_en_o = pause_rx_ff;
	assign pause_tx_en_o = pause_tx_ff;

	////////////////////////////////////////////////////////////////////////
	// register read port, data valid only in the cycle after the strobe
	always_comb
	begin
		nxt_rd_data = 16'h0000;
		if (rd_en_i && addr_i == lamp_regs_pkg::LAMP_CTRL_IDX)
		begin
			nxt_rd_data[lamp_regs_pkg::LC_RATE_LSB +: 2]  = rate_ff;
			nxt_rd_data[lamp_regs_pkg::LC_POL_LSB +: 3]   = pol_ff;
			nxt_rd_data[lamp_regs_pkg::LC_FORCE_LSB +: 3] = force_ff;
			nxt_rd_data[lamp_regs_pkg::LC_VALUE_LSB +: 3] = value_ff;
		end
		else if (rd_en_i && addr_i == lamp_regs_pkg::XCVR_CTRL_IDX)
		begin
			nxt_rd_data[lamp_regs_pkg::XC_AUTO_XOVER]     = auto_xover_ff;
			nxt_rd_data[lamp_regs_pkg::XC_FORCE_XOVER]    = force_xover_ff;
			nxt_rd_data[lamp_regs_pkg::XC_PAUSE_RX]       = pause_rx_ff;
			nxt_rd_data[lamp_regs_pkg::XC_PAUSE_TX]       = pause_tx_ff;
			nxt_rd_data[lamp_regs_pkg::XC_LINK_STAT]      = link_stat_ff;
			nxt_rd_data[lamp_regs_pkg::XC_BYPASS]         = bypass_ff;
			nxt_rd_data[lamp_regs_pkg::XC_MODE_LSB +: 2]  = mode_ff;
			nxt_rd_data[lamp_regs_pkg::XC_ADDR_LSB +: 5]  = addr_ff;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			rd_data_ff <= 16'h0000;
		else
			rd_data_ff <= nxt_rd_data;
	end

	assign rd_data_o = rd_data_ff;

	////////////////////////////////////////////////////////////////////////
	// blink timebase
	always_comb
	begin
		case (rate_ff)
			2'h0:    blink_sel = CNT_W'(BLINK_CYC_0);
			2'h1:    blink_sel = CNT_W'(BLINK_CYC_1);
			2'h2:    blink_sel = CNT_W'(BLINK_CYC_2);
			2'h3:    blink_sel = CNT_W'(BLINK_CYC_3);
			default: blink_sel = CNT_W'(BLINK_CYC_2);
		endcase
	end

	// >= keeps the count bounded when the rate drops mid-period
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			blink_cnt_ff   <= '0;
			blink_phase_ff <= 1'b0;
		end
		else if (blink_cnt_ff >= blink_sel - CNT_W'(1))
		begin
			blink_cnt_ff   <= '0;
			blink_phase_ff <= ~blink_phase_ff;
		end
		else
		begin
			blink_cnt_ff <= blink_cnt_ff + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pulse stretchers for activity and collision
	assign str_src = {status_i.collision, status_i.activity};

	for (genvar g = 0; g < 2; g++)
	begin : g_str
		always_ff @(posedge core_clk_i)
		begin
			if (!rst_n_i)
				str_cnt_ff[g] <= '0;
			else if (str_src[g])
				str_cnt_ff[g] <= CNT_W'(STRETCH_CYC);
			else if (str_cnt_ff[g] != '0)
				str_cnt_ff[g] <= str_cnt_ff[g] - CNT_W'(1);
		end
		assign str_out[g] = str_src[g] || (str_cnt_ff[g] != '0);
	end

	assign act_ev = bypass_ff ? status_i.activity  : str_out[0];
	assign col_ev = bypass_ff ? status_i.collision : str_out[1];

	////////////////////////////////////////////////////////////////////////
	// lamp mode mapping, forcing and polarity
	always_comb
	begin
		lamp_on[lamp_regs_pkg::LAMP_SPD] = status_i.speed_100;
		lamp_on[lamp_regs_pkg::LAMP_LNK] = status_i.link_up;
		lamp_on[lamp_regs_pkg::LAMP_ACT] = act_ev;
		if (!mode_ff[0] && !mode_ff[1])
		begin
			lamp_on[lamp_regs_pkg::LAMP_ACT] = col_ev;
		end
		else if (!mode_ff[0] && mode_ff[1])
		begin
			lamp_on[lamp_regs_pkg::LAMP_LNK] = status_i.link_up && !(act_ev && blink_phase_ff);
			lamp_on[lamp_regs_pkg::LAMP_ACT] = status_i.full_duplex;
		end
	end

	for (genvar l = 0; l < 3; l++)
	begin : g_lamp
		assign lamp_drv[l] = force_ff[l] ? value_ff[l] : lamp_on[l];
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			lamp_out_ff <= ~lamp_regs_pkg::POL_RST;
		else
			lamp_out_ff <= ~(lamp_drv ^ pol_ff);
	end

	assign speed_lamp_out_o    = lamp_out_ff[lamp_regs_pkg::LAMP_SPD];
	assign link_lamp_out_o     = lamp_out_ff[lamp_regs_pkg::LAMP_LNK];
	assign activity_lamp_out_o = lamp_out_ff[lamp_regs_pkg::LAMP_ACT];

	////////////////////////////////////////////////////////////////////////
	// assertions
	AST_RATE_RESET: assert property (@(posedge core_clk_i)
		$rose(rst_n_i) |-> rate_ff == 2'h2)
		else $error("blink rate not 10 after reset");

	AST_BLINK_WRAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$changed(blink_phase_ff) |-> $past(blink_cnt_ff) >= $past(blink_sel) - CNT_W'(1) && blink_cnt_ff == '0)
		else $error("blink phase toggled before terminal count");

	AST_POL_STRAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		load_pending_ff && !wr_lamp |=> pol_ff[lamp_regs_pkg::LAMP_SPD] == $past(strap_sync_ff.speed_pol)
		&& pol_ff[lamp_regs_pkg::LAMP_LNK] == $past(strap_sync_ff.link_pol))
		else $error("lamp polarity not loaded from strap");

	AST_ACT_POL_STRAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		load_pending_ff && !wr_lamp |=> pol_ff[lamp_regs_pkg::LAMP_ACT] == $past(strap_sync_ff.act_pol))
		else $error("activity polarity not loaded from strap");

	AST_FORCE_SPEED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		force_ff[lamp_regs_pkg::LAMP_SPD] |=>
		speed_lamp_out_o == ($past(value_ff[lamp_regs_pkg::LAMP_SPD]) ~^ $past(pol_ff[lamp_regs_pkg::LAMP_SPD])))
		else $error("forced speed lamp wrong");

	AST_FORCE_LINK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		force_ff[lamp_regs_pkg::LAMP_LNK] |=>
		link_lamp_out_o == ($past(value_ff[lamp_regs_pkg::LAMP_LNK]) ~^ $past(pol_ff[lamp_regs_pkg::LAMP_LNK])))
		else $error("forced link lamp wrong");

	AST_FORCE_ACT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		force_ff[lamp_regs_pkg::LAMP_ACT] |=>
		activity_lamp_out_o == ($past(value_ff[lamp_regs_pkg::LAMP_ACT]) ~^ $past(pol_ff[lamp_regs_pkg::LAMP_ACT])))
		else $error("forced activity lamp wrong");

	AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_en_i && addr_i == lamp_regs_pkg::XCVR_CTRL_IDX |=> rd_data_o[10:8] == 3'h0)
		else $error("reserved bits read nonzero");

	AST_PAUSE_FD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!(status_i.an_done && status_i.full_duplex) |=> !pause_rx_en_o && !pause_tx_en_o)
		else $error("pause enabled without full duplex");

	AST_LINK_STAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		link_stat_ff |-> $past(status_i.speed_100) && $past(status_i.an_done) && $past(status_i.link_up))
		else $error("link status set without negotiated 100 link");

	AST_MODE2_COL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		mode_ff == 2'h0 && !force_ff[lamp_regs_pkg::LAMP_ACT] && bypass_ff |=>
		activity_lamp_out_o == ($past(status_i.collision) ~^ $past(pol_ff[lamp_regs_pkg::LAMP_ACT])))
		else $error("mode 2 activity lamp does not follow collision");

	AST_RD_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!rd_en_i |=> rd_data_o == 16'h0000)
		else $error("read data outside read cycle");

endmodule

// ==== tb/lamp_model.sv ====
// external indicator lamps: which lamps glow from pin level and polarity
`timescale 1ns/1ps

module lamp_model (
	input  wire logic [2:0] pin_i,
	input  wire logic [2:0] active_high_i,
	output logic      [2:0] lit_o
);
	// a lamp glows while its pin sits at its active level
	assign lit_o = ~(pin_i ^ active_high_i);
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the lamp and transceiver control registers
`timescale 1ns/1ps

module tb;
	logic                       core_clk_i;
	logic                       rst_n_i;
	logic [4:0]                 addr_i;
	logic [15:0]                wr_data_i;
	logic                       wr_en_i;
	logic                       rd_en_i;
	logic [15:0]                rd_data_o;
	lamp_regs_pkg::phy_status_s status_i;
	lamp_regs_pkg::strap_s      strap_i;
	logic [2:0]                 pins;
	logic [2:0]                 pol;
	logic [2:0]                 lit;
	logic                       auto_xover_en_o;
	logic                       pair_swap_o;
	logic                       pause_rx_en_o;
	logic                       pause_tx_en_o;
	logic [15:0]                rdv;
	logic                       prev;
	logic                       lp;
	logic                       la;
	logic                       pp;
	logic                       pa;
	logic                       erx;
	logic                       etx;
	int                         n;
	int                         fails;
	int                         total_checks;

	led_and_phy_control_regs #(
		.BLINK_CYC_0 (8),
		.BLINK_CYC_1 (16),
		.BLINK_CYC_2 (32),
		.BLINK_CYC_3 (64),
		.STRETCH_CYC (5)
	) led_and_phy_control_regs_inst (
		.core_clk_i          (core_clk_i),
		.rst_n_i             (rst_n_i),
		.addr_i              (addr_i),
		.wr_data_i           (wr_data_i),
		.wr_en_i             (wr_en_i),
		.rd_en_i             (rd_en_i),
		.rd_data_o           (rd_data_o),
		.status_i            (status_i),
		.strap_i             (strap_i),
		.speed_lamp_out_o    (pins[2]),
		.link_lamp_out_o     (pins[1]),
		.activity_lamp_out_o (pins[0]),
		.auto_xover_en_o     (auto_xover_en_o),
		.pair_swap_o         (pair_swap_o),
		.pause_rx_en_o       (pause_rx_en_o),
		.pause_tx_en_o       (pause_tx_en_o)
	);

	lamp_model lamp_model_inst (
		.pin_i         (pins),
		.active_high_i (pol),
		.lit_o         (lit)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		wr_en_i   <= 1'b1;
		addr_i    <= a;
		wr_data_i <= d;
		@(posedge core_clk_i);
		wr_en_i   <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		rd_en_i <= 1'b1;
		addr_i  <= a;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1;
		d = rd_data_o;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		rd(a, rdv);
		chk16(rdv, exp);
	endtask

	// lamp pins are registered once, one cycle behind the unregistered status inputs
	task automatic settle();
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wrap_up();
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		fails++;
		wrap_up();
	end

	initial
	begin
		rst_n_i      = 1'b0;
		addr_i       = 5'h00;
		wr_data_i    = 16'h0000;
		wr_en_i      = 1'b0;
		rd_en_i      = 1'b0;
		status_i     = '0;
		strap_i      = '{speed_pol: 1'b1, link_pol: 1'b0, act_pol: 1'b1, auto_xover: 1'b1, mode0: 1'b1,
			port_addr: 5'h01};
		pol          = 3'h5;
		fails        = 0;
		total_checks = 0;
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rchk(5'h18, 16'h0540);
		@(posedge core_clk_i);
		#1;
		chk16(rd_data_o, 16'h0000);
		rchk(5'h19, 16'h8021);
		chk1(auto_xover_en_o, 1'b1);
		// reserved and read-only bits
		wr(5'h18, 16'hffff);
		rchk(5'h18, 16'h07ff);
		wr(5'h19, 16'hffff);
		rchk(5'h19, 16'hc0e1);
		chk1(pair_swap_o, 1'b1);
		wr(5'h19, 16'h0000);
		rchk(5'h19, 16'h0001);
		chk1(auto_xover_en_o, 1'b0);
		chk1(pair_swap_o, 1'b0);
		wr(5'h05, 16'hffff);
		rchk(5'h05, 16'h0000);
		rchk(5'h19, 16'h0001);
		// forced drive under every polarity
		for (int i = 0; i < 8; i++)
		begin
			pol = 3'(i);
			wr(5'h18, {5'h00, 2'h2, pol, 3'h7, pol ^ 3'h5});
			settle();
			chk16({13'h0, lit}, {13'h0, pol ^ 3'h5});
		end
		// mode 1 with stretch bypass
		pol = 3'h7;
		wr(5'h18, 16'h05c0);
		wr(5'h19, 16'h00a0);
		status_i.link_up   <= 1'b1;
		status_i.speed_100 <= 1'b1;
		status_i.activity  <= 1'b1;
		settle();
		chk16({13'h0, lit}, 16'h0007);
		@(posedge core_clk_i);
		status_i.activity  <= 1'b0;
		status_i.speed_100 <= 1'b0;
		settle();
		chk16({13'h0, lit}, 16'h0002);
		// stretched activity pulse
		wr(5'h19, 16'h0020);
		status_i.activity <= 1'b1;
		@(posedge core_clk_i);
		status_i.activity <= 1'b0;
		settle();
		chk1(lit[0], 1'b1);
		repeat (10) @(posedge core_clk_i);
		#1;
		chk1(lit[0], 1'b0);
		// mode 2: collision on the activity lamp
		wr(5'h19, 16'h0080);
		status_i.collision <= 1'b1;
		settle();
		chk16({13'h0, lit}, 16'h0003);
		@(posedge core_clk_i);
		status_i.collision <= 1'b0;
		status_i.activity  <= 1'b1;
		settle();
		chk16({13'h0, lit}, 16'h0002);
		// mode 2 without bypass: stretched collision pulse
		wr(5'h19, 16'h0000);
		status_i.collision <= 1'b1;
		@(posedge core_clk_i);
		status_i.collision <= 1'b0;
		settle();
		chk1(lit[0], 1'b1);
		repeat (10) @(posedge core_clk_i);
		#1;
		chk1(lit[0], 1'b0);
		// mode 3: link lamp blinks at each rate
		wr(5'h19, 16'h00c0);
		for (int r = 0; r < 4; r++)
		begin
			wr(5'h18, {5'h00, 2'(r), 9'h1c0});
			#1;
			n    = 0;
			prev = lit[1];
			repeat (256)
			begin
				@(posedge core_clk_i);
				#1;
				if (lit[1] !== prev)
					n++;
				prev = lit[1];
			end
			chk1(n >= (32 >> r) - 1 && n <= (32 >> r) + 1, 1'b1);
		end
		@(posedge core_clk_i);
		status_i.activity    <= 1'b0;
		status_i.full_duplex <= 1'b1;
		settle();
		chk16({13'h0, lit}, 16'h0003);
		// pause resolution and negotiated link status
		status_i.an_done   <= 1'b1;
		status_i.speed_100 <= 1'b1;
		for (int k = 0; k < 32; k++)
		begin
			@(posedge core_clk_i);
			{status_i.full_duplex, status_i.local_pause, status_i.partner_pause} <= 5'(k);
			settle();
			lp  = status_i.local_pause[0];
			la  = status_i.local_pause[1];
			pp  = status_i.partner_pause[0];
			pa  = status_i.partner_pause[1];
			erx = k[4] & ((lp & pp) | (lp & la & ~pp & pa));
			etx = k[4] & ((lp & pp) | (~lp & la & pp & pa));
			rchk(5'h19, {2'h0, erx, etx, k[4], 11'h0c1});
			chk16({14'h0, pause_rx_en_o, pause_tx_en_o}, {14'h0, erx, etx});
		end
		@(posedge core_clk_i);
		status_i.speed_100 <= 1'b0;
		settle();
		rchk(5'h19, 16'h30c1);
		@(posedge core_clk_i);
		status_i.an_done <= 1'b0;
		settle();
		rchk(5'h19, 16'h00c1);
		// second reset with straps that differ from every first-reset strap value
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		strap_i <= '{speed_pol: 1'b0, link_pol: 1'b1, act_pol: 1'b0, auto_xover: 1'b0, mode0: 1'b0,
			port_addr: 5'h0a};
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rchk(5'h18, 16'h0480);
		rchk(5'h19, 16'h000a);
		chk1(auto_xover_en_o, 1'b0);
		wrap_up();
	end
endmodule
